// *** core/spi_bus_master.sv ***
// four-wire serial peripheral master with a classic Wishbone register port
// assumes the slave answers on serial_data_in synchronous to clock
`timescale 1ns/100ps

module spi_bus_master (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // wishbone register port
  input  wire logic        cyc,
  input  wire logic        stb,
  input  wire logic        we,
  input  wire logic [7:0]  adr,
  input  wire logic [3:0]  sel,
  input  wire logic [31:0] dat_w,
  output logic      [31:0] dat_r,
  output logic             ack,
  // serial bus
  output logic             serial_clock_out,
  output logic             serial_data_out,
  input  wire logic        serial_data_in,
  output logic             master_ready_select_n,
  output logic             pins_oe_n
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  function automatic logic [31:0] low_mask(input logic [5:0] n);
    logic [31:0] m;
    m = 32'hFFFF_FFFF;
    if (n < spi_pkg::LEN_MAX) begin
      m = ~(32'hFFFF_FFFF << n);
    end
    return m;
  endfunction : low_mask

  function automatic logic [7:0] clamp_range(input logic [7:0] v,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi);
    logic [7:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction : clamp_range

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  spi_pkg::ctrl_s      ctrl_q,  ctrl_d;
  logic [7:0]          div_q,   div_d;
  logic [31:0]         rx_q,    rx_d;
  logic                done_q,  done_d;
  logic                drop_q,  drop_d;
  logic                ack_q,   ack_d;
  logic [31:0]         rdat_q,  rdat_d;
  spi_pkg::spi_state_e st_q,    st_d;
  logic [31:0]         tx_sh_q, tx_sh_d;
  logic [31:0]         rx_sh_q, rx_sh_d;
  logic [5:0]          wlen_q,  wlen_d;
  logic                wcpha_q, wcpha_d;
  logic [6:0]          edge_q,  edge_d;
  spi_pkg::pins_s      pins_q,  pins_d;
  logic                oe_n_q,  oe_n_d;

  logic                req;
  logic                wr;
  logic                tick;
  logic                leading;
  logic [31:0]         wrd;
  logic [31:0]         ctrl_rd;
  logic [5:0]          len_cl;
  logic [7:0]          half_cl;
  logic                tx_wr;
  logic                busy;

  // ack_q gates req so a strobe held over the ack cycle is taken once
  assign req   = cyc & stb & ~ack_q;
  assign wr    = req & we;
  assign tx_wr = wr && adr == spi_pkg::OFS_TX;
  assign busy  = st_q != spi_pkg::ST_IDLE;

  assign len_cl  = 6'(clamp_range({2'b00, ctrl_q.len}, {2'b00, spi_pkg::LEN_MIN},
                                  {2'b00, spi_pkg::LEN_MAX}));
  assign half_cl = clamp_range(div_q, spi_pkg::HALF_MIN, spi_pkg::HALF_MAX);

  assign ctrl_rd = {18'h0_0000, ctrl_q.len, 5'h00, ctrl_q.en, ctrl_q.cpha, ctrl_q.cpol};
  assign leading = ~edge_q[0];

  // ----------------------------------------------------------------
  // serial clock divider
  // ----------------------------------------------------------------
  // half-period ticks
  spi_rate_tick u_tick (
    .clock (clock),
    .rst   (rst),
    .run   (busy),
    .half  (half_cl),
    .tick  (tick)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d  = ctrl_q;
    div_d   = div_q;
    rx_d    = rx_q;
    done_d  = done_q;
    drop_d  = drop_q;
    ack_d   = req;
    rdat_d  = rdat_q;
    st_d    = st_q;
    tx_sh_d = tx_sh_q;
    rx_sh_d = rx_sh_q;
    wlen_d  = wlen_q;
    wcpha_d = wcpha_q;
    edge_d  = edge_q;
    pins_d  = pins_q;
    // pads stay driven until a running word has ended
    oe_n_d  = ~(ctrl_q.en | busy);
    wrd     = 32'h0000_0000;

    // register reads and writes
    if (req) begin
      rdat_d = 32'h0000_0000;
      if (adr == spi_pkg::OFS_CTRL) begin
        rdat_d = ctrl_rd;
        if (we) begin
          wrd         = lane_merge(ctrl_rd, dat_w, sel);
          ctrl_d.cpol = wrd[spi_pkg::CTRL_CPOL];
          ctrl_d.cpha = wrd[spi_pkg::CTRL_CPHA];
          ctrl_d.en   = wrd[spi_pkg::CTRL_EN];
          ctrl_d.len  = wrd[spi_pkg::CTRL_LEN +: 6];
        end
      end else if (adr == spi_pkg::OFS_DIV) begin
        rdat_d = {24'h00_0000, div_q};
        if (we) begin
          wrd   = lane_merge({24'h00_0000, div_q}, dat_w, sel);
          div_d = wrd[7:0];
        end
      end else if (adr == spi_pkg::OFS_RX) begin
        rdat_d = rx_q;
      end else if (adr == spi_pkg::OFS_STAT) begin
        rdat_d[spi_pkg::STAT_BUSY] = busy;
        rdat_d[spi_pkg::STAT_DONE] = done_q;
        rdat_d[spi_pkg::STAT_DROP] = drop_q;
        if (we && sel[0]) begin
          done_d = done_q & ~dat_w[spi_pkg::STAT_DONE];
          drop_d = drop_q & ~dat_w[spi_pkg::STAT_DROP];
        end
      end
    end

    // serial engine
    case (st_q)
      spi_pkg::ST_IDLE: begin
        pins_d.sclk = ctrl_q.cpol;
        pins_d.ss_n = 1'b1;
        if (tx_wr && ctrl_q.en) begin
          wrd     = lane_merge(32'h0000_0000, dat_w, sel);
          tx_sh_d = 32'(wrd << (6'h20 - len_cl));
          wlen_d  = len_cl;
          wcpha_d = ctrl_q.cpha;
          edge_d  = 7'h00;
          pins_d.ss_n = 1'b0;
          st_d        = spi_pkg::ST_SETUP;
          if (!ctrl_q.cpha) begin
            // first bit ahead of the leading edge
            pins_d.mosi = tx_sh_d[31];
            tx_sh_d     = {tx_sh_d[30:0], 1'b0};
          end
        end else if (tx_wr) begin
          drop_d = 1'b1;
        end
      end
      spi_pkg::ST_SETUP: begin
        if (tick) begin
          st_d = spi_pkg::ST_RUN;
        end
      end
      spi_pkg::ST_RUN: begin
        if (tick) begin
          // toggle, then drive or sample per phase
          pins_d.sclk = ~pins_q.sclk;
          edge_d      = 7'(edge_q + 7'h01);
          if (leading ^ wcpha_q) begin
            rx_sh_d = {rx_sh_q[30:0], serial_data_in};
          end else if (edge_d != {wlen_q, 1'b0}) begin
            pins_d.mosi = tx_sh_q[31];
            tx_sh_d     = {tx_sh_q[30:0], 1'b0};
          end
          if (edge_d == {wlen_q, 1'b0}) begin
            st_d = spi_pkg::ST_HOLD;
          end
        end
      end
      spi_pkg::ST_HOLD: begin
        if (tick) begin
          // select held past the last bit
          pins_d.ss_n = 1'b1;
          rx_d        = rx_sh_q & low_mask(wlen_q);
          done_d      = 1'b1;
          st_d        = spi_pkg::ST_IDLE;
        end
      end
      default: begin
        st_d = spi_pkg::ST_IDLE;
      end
    endcase

    // a drop caught with a clear still counts
    if (!busy && tx_wr && !ctrl_q.en) begin
      drop_d = 1'b1;
    end
    if (busy && tx_wr) begin
      drop_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q  <= '{len: spi_pkg::LEN_RST, en: 1'b0, cpha: 1'b0, cpol: 1'b0};
      div_q   <= spi_pkg::DIV_RST;
      rx_q    <= spi_pkg::WORD_RST;
      done_q  <= 1'b0;
      drop_q  <= 1'b0;
      ack_q   <= 1'b0;
      rdat_q  <= spi_pkg::WORD_RST;
      st_q    <= spi_pkg::ST_IDLE;
      tx_sh_q <= spi_pkg::WORD_RST;
      rx_sh_q <= spi_pkg::WORD_RST;
      wlen_q  <= spi_pkg::LEN_RST;
      wcpha_q <= 1'b0;
      edge_q  <= 7'h00;
      pins_q  <= '{sclk: 1'b0, mosi: 1'b0, ss_n: 1'b1};
      oe_n_q  <= 1'b1;
    end else begin
      ctrl_q  <= ctrl_d;
      div_q   <= div_d;
      rx_q    <= rx_d;
      done_q  <= done_d;
      drop_q  <= drop_d;
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
      st_q    <= st_d;
      tx_sh_q <= tx_sh_d;
      rx_sh_q <= rx_sh_d;
      wlen_q  <= wlen_d;
      wcpha_q <= wcpha_d;
      edge_q  <= edge_d;
      pins_q  <= pins_d;
      oe_n_q  <= oe_n_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dat_r                 = rdat_q;
  assign ack                   = ack_q;
  assign serial_clock_out      = pins_q.sclk;
  assign serial_data_out       = pins_q.mosi;
  assign master_ready_select_n = pins_q.ss_n;
  assign pins_oe_n             = oe_n_q;

endmodule : spi_bus_master

// *** core/spi_pkg.sv ***
// constants, register map and carrier types of the serial peripheral master
// assumes a 250 MHz core clock and a 32-bit classic Wishbone register port
package spi_pkg;

  // ----------------------------------------------------------------
  // clock and bit-rate limits
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ  = 250_000_000;
  localparam int unsigned MIN_BPS = 960_000;
  localparam int unsigned MAX_BPS = 25_000_000;
  // half serial period in core cycles: fastest rounds up, slowest rounds down
  localparam logic [7:0] HALF_MIN = 8'((CLK_HZ + 2 * MAX_BPS - 1) / (2 * MAX_BPS));
  localparam logic [7:0] HALF_MAX = 8'(CLK_HZ / (2 * MIN_BPS));

  // ----------------------------------------------------------------
  // word length limits
  // ----------------------------------------------------------------
  localparam logic [5:0] LEN_MIN = 6'h04;
  localparam logic [5:0] LEN_MAX = 6'h20;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIV  = 8'h04;
  localparam logic [7:0] OFS_TX   = 8'h08;
  localparam logic [7:0] OFS_RX   = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_CPOL = 0;
  localparam int unsigned CTRL_CPHA = 1;
  localparam int unsigned CTRL_EN   = 2;
  localparam int unsigned CTRL_LEN  = 8;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_DONE = 1;
  localparam int unsigned STAT_DROP = 2;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [5:0]  LEN_RST  = 6'h20;
  localparam logic [7:0]  DIV_RST  = 8'h82;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] len;
    logic       en;
    logic       cpha;
    logic       cpol;
  } ctrl_s;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic ss_n;
  } pins_s;

  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_RUN, ST_HOLD} spi_state_e;

endpackage : spi_pkg

// *** core/spi_rate_tick.sv ***
// half-period enable generator for the serial clock
// assumes half is already clamped to the legal range by the caller
`timescale 1ns/100ps

module spi_rate_tick (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // control
  input  wire logic       run,
  input  wire logic [7:0] half,
  // enable out
  output logic            tick
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       tick_q;
  logic       tick_d;

  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (!run) begin
      cnt_d = 8'h00;
    // >= so a shorter half taken mid-word ends the count at once
    end else if (cnt_q >= 8'(half - 8'h01)) begin
      cnt_d  = 8'h00;
      tick_d = 1'b1;
    end else begin
      cnt_d = 8'(cnt_q + 8'h01);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d & run;
    end
  end

  assign tick = tick_q & run;

endmodule : spi_rate_tick

// *** tb/spi_bus_master_properties.sv ***
// checker of the serial master's port timing
// assumes one clock domain and binding to spi_bus_master
`timescale 1ns/100ps
module spi_bus_master_properties (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // register port
  input wire logic        cyc,
  input wire logic        stb,
  input wire logic        ack,
  // serial bus
  input wire logic        serial_clock_out,
  input wire logic        master_ready_select_n,
  input wire logic        pins_oe_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic       sclk_q;
  logic [6:0] edges_q;
  logic [6:0] edges_d;
  // serial clock edges within one frame
  always_comb begin
    edges_d = master_ready_select_n ? 7'h00 : edges_q + 7'(serial_clock_out != sclk_q);
  end
  always_ff @(posedge clock) begin
    sclk_q  <= serial_clock_out;
    edges_q <= edges_d;
  end
  a_ack_answer: assert property (cyc && stb && !ack |=> ack)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack held past one cycle");
  a_select_lead: assert property ($fell(master_ready_select_n) |->
    $stable(serial_clock_out)[*4])
    else $error("clock edge too soon after select");
  a_select_tail: assert property ($rose(master_ready_select_n) |->
    serial_clock_out == $past(serial_clock_out, 4))
    else $error("select released too soon after last edge");
  a_frame_edges: assert property ($rose(master_ready_select_n) |->
    !edges_q[0] && edges_q >= 7'h08 && edges_q <= 7'h40)
    else $error("edge count of frame out of range");
  a_half_min: assert property ($changed(serial_clock_out) |=> $stable(serial_clock_out)[*4])
    else $error("serial clock faster than upper rate");
  a_half_max: assert property ($changed(serial_clock_out) && !master_ready_select_n |->
    ##[1:130] ($changed(serial_clock_out) || master_ready_select_n))
    else $error("serial clock slower than lower rate");
  a_idle_when_off: assert property (pins_oe_n |-> master_ready_select_n)
    else $error("frame while pads disabled");
endmodule : spi_bus_master_properties

bind spi_bus_master spi_bus_master_properties i_spi_bus_master_properties (
  .clock(clock), .rst(rst), .cyc(cyc), .stb(stb), .ack(ack),
  .serial_clock_out(serial_clock_out), .master_ready_select_n(master_ready_select_n),
  .pins_oe_n(pins_oe_n));

// *** tb/spi_slave_model.sv ***
// behavioural slave on the serial bus
// assumes mode and length are set by the bench before each frame
`timescale 1ns/100ps
module spi_slave_model (
  // clock and setup
  input wire logic        clock,
  input wire logic        cpol,
  input wire logic        cpha,
  input wire logic [5:0]  len,
  input wire logic [31:0] reply,
  // serial bus
  input wire logic        sclk,
  input wire logic        mosi,
  input wire logic        ss_n,
  output logic            miso,
  output logic [31:0]     got
);
  logic        sclk_q, ss_q, lead, trail;
  logic [31:0] sh;
  initial begin
    miso = 1'b0; got = 32'h0; sh = 32'h0; sclk_q = 1'b0; ss_q = 1'b1;
  end
  assign lead  = (sclk != sclk_q) && (sclk_q == cpol);
  assign trail = (sclk != sclk_q) && (sclk_q != cpol);
  // reply msb first, toggling while released
  always @(posedge clock) begin
    sclk_q <= sclk;
    ss_q   <= ss_n;
    if (ss_n) begin
      miso <= ~miso;
    end else if (ss_q) begin
      got  <= 32'h0;
      sh   <= reply << (6'h20 - len);
      if (!cpha) begin
        miso <= reply[len - 6'h01];
        sh   <= reply << (6'h21 - len);
      end
    end else begin
      if (cpha ? lead : trail) begin
        miso <= sh[31];
        sh   <= sh << 1;
      end
      if (cpha ? trail : lead) got <= {got[30:0], mosi};
    end
  end
endmodule : spi_slave_model

// *** tb/spi_bus_master_tb_top.sv ***
// self-checking bench driving the master through its register port
// assumes the slave model on the serial side and a 250 MHz clock
`timescale 1ns/100ps
module spi_bus_master_tb_top;
  logic        clock, rst, cyc, stb, we, ack, sclk, mosi, miso, ss_n, oe_n, cpol, cpha;
  logic [7:0]  adr;
  logic [3:0]  sel, wsel;
  logic [5:0]  mlen;
  logic [31:0] dat_w, dat_r, reply, got, rd;
  int          error_cnt, checks, low_cnt;
  logic [7:0]  ra [6] = '{spi_pkg::OFS_CTRL, spi_pkg::OFS_DIV, spi_pkg::OFS_STAT,
                          spi_pkg::OFS_TX, spi_pkg::OFS_RX, 8'h14};
  logic [31:0] re [6] = '{32'h0000_2000, 32'h0000_0082, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [5:0]  lw [4] = '{6'h02, 6'h20, 6'h0D, 6'h28};
  logic [5:0]  le [4] = '{6'h04, 6'h20, 6'h0D, 6'h20};
  spi_bus_master i_spi_bus_master (.clock(clock), .rst(rst), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat_w(dat_w), .dat_r(dat_r), .ack(ack), .serial_clock_out(sclk),
    .serial_data_out(mosi), .serial_data_in(miso), .master_ready_select_n(ss_n),
    .pins_oe_n(oe_n));
  spi_slave_model i_spi_slave_model (.clock(clock), .cpol(cpol), .cpha(cpha), .len(mlen),
    .reply(reply), .sclk(sclk), .mosi(mosi), .ss_n(ss_n), .miso(miso), .got(got));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) if (ss_n === 1'b0) low_cnt <= low_cnt + 1;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d; sel <= wsel;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    q = dat_r;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clock);
  endtask : wb
  task automatic xfer(input logic [1:0] m, input logic [5:0] lw_v, input logic [5:0] le_v,
                      input logic [7:0] dv, input logic [31:0] tx, input logic dbl);
    logic [31:0] mask;
    int          n;
    mask = (le_v == 6'h20) ? 32'hFFFF_FFFF : (32'h1 << le_v) - 32'h1;
    cpol <= m[1]; cpha <= m[0]; mlen <= le_v; reply <= ~tx; low_cnt <= 0;
    wb(1'b1, spi_pkg::OFS_DIV, {24'h0, dv}, rd);
    wb(1'b1, spi_pkg::OFS_CTRL, {18'h0, lw_v, 5'h00, 1'b1, m[0], m[1]}, rd);
    wb(1'b1, spi_pkg::OFS_TX, tx, rd);
    if (dbl) wb(1'b1, spi_pkg::OFS_TX, ~tx, rd);
    n = 0;
    rd = 32'h0;
    while (rd[1] !== 1'b1 && n < 2000) begin
      wb(1'b0, spi_pkg::OFS_STAT, 32'h0, rd);
      n++;
    end
    chk(rd & 32'h7, dbl ? 32'h6 : 32'h2);
    chk(got & mask, tx & mask);
    wb(1'b0, spi_pkg::OFS_RX, 32'h0, rd);
    chk(rd, ~tx & mask);
    wb(1'b1, spi_pkg::OFS_STAT, 32'h6, rd);
  endtask : xfer
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    #(4 * 40000);
    error_cnt++;
    give_verdict();
  end
  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; wsel = 4'hF;
    dat_w = 32'h0; cpol = 1'b0; cpha = 1'b0; mlen = 6'h20; reply = 32'h0; low_cnt = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    chk({31'h0, oe_n}, 32'h1);
    chk({31'h0, ss_n}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, ra[i], 32'h0, rd);
      chk(rd, re[i]);
    end
    wb(1'b1, spi_pkg::OFS_TX, 32'h5, rd);
    repeat (20) @(posedge clock);
    chk({31'h0, ss_n}, 32'h1);
    wb(1'b0, spi_pkg::OFS_STAT, 32'h0, rd);
    chk(rd & 32'h7, 32'h4);
    wb(1'b1, spi_pkg::OFS_STAT, 32'h4, rd);
    for (int m = 0; m < 4; m++) begin
      xfer(2'(m), lw[m], le[m], 8'h05, 32'hA5C3_96E1 ^ 32'(m), 1'b0);
      xfer(2'(m), 6'h20, 6'h20, 8'h01, 32'h9B2D_47F0 + 32'(m), m == 3);
    end
    chk({31'h0, oe_n}, 32'h0);
    xfer(2'h0, 6'h04, 6'h04, 8'hFF, 32'h0000_0009, 1'b0);
    chk(32'(low_cnt >= 1040 && low_cnt <= 1430), 32'h1);
    xfer(2'h1, 6'h04, 6'h04, 8'h00, 32'h0000_0006, 1'b0);
    chk(32'(low_cnt >= 40 && low_cnt <= 60), 32'h1);
    // byte lane 0 only: the length lane must survive
    wsel = 4'h1;
    wb(1'b1, spi_pkg::OFS_CTRL, 32'h0000_3F00, rd);
    wsel = 4'hF;
    wb(1'b0, spi_pkg::OFS_CTRL, 32'h0, rd);
    chk(rd, {18'h0, 6'h04, 8'h00});
    chk({31'h0, oe_n}, 32'h1);
    // second reset while the engine is idle restores the divider
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    wb(1'b0, spi_pkg::OFS_DIV, 32'h0, rd);
    chk(rd, {24'h00_0000, spi_pkg::DIV_RST});
    give_verdict();
  end
endmodule : spi_bus_master_tb_top
